// >>> logic/cmt_lamp_timer.sv
// Interval timer that holds the lamp test active for a fixed time.
// Assumes start is a one-cycle pulse; a start while running is ignored.
`timescale 1ns/10ps
module cmt_lamp_timer
	import cmt_pkg::*;
#(
	parameter int CYCLES = LAMP_CYCLES
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	output logic active_out
);
	typedef struct packed {
		cmt_lamp_st_t st;
		logic [25:0] cnt;
	} cmt_lt_s_t;
	cmt_lt_s_t s_r;
	cmt_lt_s_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			LT_IDLE: begin
				if (start_in) begin
					s_nxt.st = LT_ON;
					s_nxt.cnt = 26'h0;
				end
			end
			LT_ON: begin
				s_nxt.cnt = s_r.cnt + 26'h1;
				if (s_r.cnt == 26'(CYCLES - 1)) begin
					s_nxt.st = LT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_r <= '{st: LT_IDLE, cnt: 26'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign active_out = (s_r.st == LT_ON);

	property p_lamp_end;
		@(posedge clk_in) disable iff (!rstn_in)
		(s_r.st == LT_ON && s_r.cnt == 26'(CYCLES - 1)) |=> !active_out;
	endproperty
	a_lamp_end: assert property (p_lamp_end)
		else $error("Lamp test interval did not end on time.");
endmodule

// >>> logic/cmt_pkg.sv
// Constants, types and helpers of the commissioning test control block.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
// Function
// - Eight probe selectors each hold a signal index from 0 to 511.
// - Eight probed signal states are readable as one eight-bit view.
// - Each probed state also drives its own monitor port pin.
// - Opto input states are readable, 1 energised, 0 de-energised.
// - Output relay command signals are readable, 1 meaning operated.
// - With outputs blocked the relay view still shows scheme commands.
// - Eight indicator lamps are readable, 1 lit, 0 unlit.
// - Test state: out of service, alarm, lamp lit, wear record frozen; the code drives no lamp for the test state.
// - Blocked test state stops scheme logic driving any output relay.
// - Protection channel keeps running while outputs are blocked.
// - An energised test mode opto input also forces the test state.
// - In the 103 protocol build, test is reported as transmission cause.
// - Test pattern has one bit per contact, 1 selects it, resets to 0.
// - Apply holds pattern contacts until remove; command reverts to none.
// - Lamp test lights all eight lamps about 2 s, then command reverts.
// - Three-pole reclose test runs a cycle; command clears at trip.
// - Pole A, B and C commands run single-pole cycles where available.
// - Either loopback forces the protection address to 0-0.
// - Internal loopback routes transmitter straight to own receiver.
package cmt_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int LAMP_TEST_MS = 2000;
	localparam int LAMP_CYCLES = LAMP_TEST_MS * (CLK_HZ / 1000);
	localparam int BUS_W = 512;
	localparam int SEL_W = 9;
	localparam int NPROBE = 8;
	localparam int NRELAY = 32;
	localparam int NOPTO = 32;
	localparam int NLAMP = 8;
	localparam int AR_RELAY = 2;

	// ***************************************************
	// Register map
	// ***************************************************
	localparam logic [7:0] OFS_PROBE0 = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h20;
	localparam logic [7:0] OFS_PATTERN = 8'h24;
	localparam logic [7:0] OFS_CMD = 8'h28;
	localparam logic [7:0] OFS_LOOP = 8'h2C;
	localparam logic [7:0] OFS_PADDR = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_OPTO = 8'h38;
	localparam logic [7:0] OFS_RELAY = 8'h3C;
	localparam logic [7:0] OFS_VIEW = 8'h40;
	localparam int CMD_LAMP_BIT = 2;
	localparam int CMD_AR_LSB = 4;
	localparam logic [NPROBE-1:0][SEL_W-1:0] PROBE_SEL_RST = {
		9'h047, 9'h046, 9'h045, 9'h044,
		9'h043, 9'h042, 9'h041, 9'h040};
	localparam logic [NRELAY-1:0] PATTERN_RST = 32'h0000_0000;
	localparam logic [15:0] PADDR_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***************************************************
	// Modes and commands
	// ***************************************************
	localparam logic [1:0] TM_OFF = 2'h0;
	localparam logic [1:0] TM_TEST = 2'h1;
	localparam logic [1:0] TM_BLOCK = 2'h2;
	localparam logic [1:0] CC_NOP = 2'h0;
	localparam logic [1:0] CC_APPLY = 2'h1;
	localparam logic [1:0] CC_REMOVE = 2'h2;
	localparam logic [2:0] AR_NOP = 3'h0;
	localparam logic [2:0] AR_3P = 3'h1;
	localparam logic [2:0] AR_PA = 3'h2;
	localparam logic [2:0] AR_PB = 3'h3;
	localparam logic [2:0] AR_PC = 3'h4;
	localparam logic [1:0] LB_OFF = 2'h0;
	localparam logic [1:0] LB_EXT = 2'h1;
	localparam logic [1:0] LB_INT = 2'h2;

	typedef enum logic [1:0] {LT_IDLE = 2'b01, LT_ON = 2'b10} cmt_lamp_st_t;

	// Byte-enable merge, so partial writes keep the untouched lanes.
	function automatic logic [31:0] cmt_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction
endpackage

// >>> logic/cmt_probe_mux.sv
// Eight 512-way selectors of internal signal bus bits for the monitor probes.
// Assumes the bus is synchronous to the clock.
`timescale 1ns/10ps
module cmt_probe_mux
	import cmt_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [BUS_W-1:0] bus_in,
	input wire logic [NPROBE-1:0][SEL_W-1:0] sel_in,
	output logic [NPROBE-1:0] probe_out
);
	typedef struct packed {
		logic [NPROBE-1:0] q;
	} cmt_mux_s_t;
	cmt_mux_s_t s_r;
	cmt_mux_s_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < NPROBE; i++) begin
			s_nxt.q[i] = bus_in[sel_in[i]];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign probe_out = s_r.q;

	property p_probe_sel;
		@(posedge clk_in) disable iff (!rstn_in)
		1'b1 |=> probe_out[1:0]
			== $past({bus_in[sel_in[1]], bus_in[sel_in[0]]});
	endproperty
	a_probe_sel: assert property (p_probe_sel)
		else $error("Probe pin does not follow the selected bus bit.");
endmodule

// >>> logic/cmt_top.sv
// Commissioning test control: probes, views, test modes, contact and
// lamp tests, reclose test commands and protection channel loopback.
// Assumes an AXI4-Lite master with one write and one read outstanding.
`timescale 1ns/10ps
module cmt_top
	import cmt_pkg::*;
#(
	parameter int LAMP_TICKS = LAMP_CYCLES
)
(
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [7:0] AXI_AWADDR_IN,
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	output logic [1:0] AXI_BRESP_OUT,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	input wire logic [7:0] AXI_ARADDR_IN,
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	input wire logic [BUS_W-1:0] INT_BUS_IN,
	input wire logic [NOPTO-1:0] OPTO_IN,
	input wire logic [NRELAY-1:0] SCHEME_OUT_IN,
	input wire logic [NLAMP-1:0] LAMP_IN,
	input wire logic TEST_OPTO_IN,
	input wire logic SP_AR_IN,
	input wire logic PROTO103_IN,
	input wire logic CHAN_TX_IN,
	input wire logic CHAN_RX_LINE_IN,
	output logic [NPROBE-1:0] PROBE_OUT,
	output logic [NRELAY-1:0] RELAY_OUT,
	output logic [NLAMP-1:0] LAMP_OUT,
	output logic OOS_OUT,
	output logic ALARM_OUT,
	output logic FREEZE_OUT,
	output logic CAUSE_TEST_OUT,
	output logic [3:0] AR_TRIP_OUT,
	output logic [15:0] PROT_ADDR_OUT,
	output logic CHAN_TX_LINE_OUT,
	output logic CHAN_RX_OUT
);
	// ***************************************************
	// State
	// ***************************************************
	typedef struct packed {
		logic [NPROBE-1:0][SEL_W-1:0] sel;
		logic [1:0] mode;
		logic [NRELAY-1:0] pattern;
		logic contact_act;
		logic [1:0] ccmd;
		logic lamp_go;
		logic [2:0] ar_cmd;
		logic [1:0] loop;
		logic [15:0] paddr;
		logic aw_held;
		logic [7:0] waddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NRELAY-1:0] relay;
		logic [NLAMP-1:0] lamp;
		logic oos;
		logic alarm;
		logic freeze;
		logic cause;
		logic [3:0] ar_trip;
		logic [15:0] paddr_out;
		logic tx_line;
		logic rx_out;
	} cmt_top_s_t;
	cmt_top_s_t s_r;
	cmt_top_s_t s_nxt;
	logic lamp_act;
	logic [NPROBE-1:0] probe;
	logic in_test;
	logic blocked;
	logic [NRELAY-1:0] base;
	logic [31:0] m;

	cmt_probe_mux u_mux (
		.clk_in(REF_CLK_IN),
		.rstn_in(RSTN_IN),
		.bus_in(INT_BUS_IN),
		.sel_in(s_r.sel),
		.probe_out(probe)
	);

	cmt_lamp_timer #(.CYCLES(LAMP_TICKS)) u_lamp (
		.clk_in(REF_CLK_IN),
		.rstn_in(RSTN_IN),
		.start_in(s_r.lamp_go),
		.active_out(lamp_act)
	);

	// ***************************************************
	// Next state
	// ***************************************************
	always_comb begin
		s_nxt = s_r;
		m = 32'h0000_0000;
		in_test = (s_r.mode != TM_OFF) || TEST_OPTO_IN;
		blocked = (s_r.mode == TM_BLOCK);
		s_nxt.lamp_go = 1'b0;
		// A contact command acts once, then the selector reads as none.
		s_nxt.ccmd = CC_NOP;
		if (s_r.ccmd == CC_APPLY) begin
			s_nxt.contact_act = 1'b1;
		end else if (s_r.ccmd == CC_REMOVE) begin
			s_nxt.contact_act = 1'b0;
		end
		// Single-pole commands are dropped where no such reclosing exists.
		if (s_r.ar_cmd != AR_NOP) begin
			if (SCHEME_OUT_IN[AR_RELAY]) begin
				s_nxt.ar_cmd = AR_NOP;
			end else if (!SP_AR_IN && s_r.ar_cmd != AR_3P) begin
				s_nxt.ar_cmd = AR_NOP;
			end else if (s_r.ar_cmd > AR_PC) begin
				s_nxt.ar_cmd = AR_NOP;
			end
		end

		if (AXI_AWVALID_IN && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.waddr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata = AXI_WDATA_IN;
			s_nxt.wstrb = AXI_WSTRB_IN;
		end
		if (AXI_BREADY_IN && s_r.bvalid) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (s_r.waddr[7:5] == OFS_PROBE0[7:5] && s_r.waddr[1:0] == 2'h0) begin
				m = cmt_merge(32'(s_r.sel[s_r.waddr[4:2]]), s_r.wdata,
					s_r.wstrb);
				s_nxt.sel[s_r.waddr[4:2]] = m[SEL_W-1:0];
			end else begin
				unique case (s_r.waddr)
					OFS_MODE: begin
						m = cmt_merge(32'(s_r.mode), s_r.wdata, s_r.wstrb);
						s_nxt.mode = m[1:0];
					end
					OFS_PATTERN: begin
						m = cmt_merge(s_r.pattern, s_r.wdata, s_r.wstrb);
						s_nxt.pattern = m;
					end
					OFS_CMD: begin
						m = cmt_merge(32'h0, s_r.wdata, s_r.wstrb);
						s_nxt.ccmd = m[1:0];
						s_nxt.lamp_go = m[CMD_LAMP_BIT] && !lamp_act;
						if (m[CMD_AR_LSB +: 3] != AR_NOP) begin
							s_nxt.ar_cmd = m[CMD_AR_LSB +: 3];
						end
					end
					OFS_LOOP: begin
						m = cmt_merge(32'(s_r.loop), s_r.wdata, s_r.wstrb);
						s_nxt.loop = m[1:0];
					end
					OFS_PADDR: begin
						m = cmt_merge(32'(s_r.paddr), s_r.wdata, s_r.wstrb);
						s_nxt.paddr = m[15:0];
					end
					default: begin
						s_nxt.bresp = RESP_SLVERR;
					end
				endcase
			end
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

		if (AXI_RREADY_IN && s_r.rvalid) begin
			s_nxt.rvalid = 1'b0;
		end
		if (AXI_ARVALID_IN && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (AXI_ARADDR_IN[7:5] == OFS_PROBE0[7:5]
				&& AXI_ARADDR_IN[1:0] == 2'h0) begin
				s_nxt.rdata = 32'(s_r.sel[AXI_ARADDR_IN[4:2]]);
			end else begin
				unique case (AXI_ARADDR_IN)
					OFS_MODE: s_nxt.rdata = 32'(s_r.mode);
					OFS_PATTERN: s_nxt.rdata = s_r.pattern;
					OFS_CMD: begin
						s_nxt.rdata[1:0] = s_r.ccmd;
						s_nxt.rdata[CMD_LAMP_BIT] = s_r.lamp_go || lamp_act;
						s_nxt.rdata[CMD_AR_LSB +: 3] = s_r.ar_cmd;
					end
					OFS_LOOP: s_nxt.rdata = 32'(s_r.loop);
					OFS_PADDR: s_nxt.rdata = 32'(s_r.paddr);
					OFS_STATUS: begin
						s_nxt.rdata[3:0] = {lamp_act, s_r.contact_act,
							blocked, s_r.oos};
					end
					OFS_OPTO: s_nxt.rdata = OPTO_IN;
					// Shows scheme commands even while contacts are blocked.
					OFS_RELAY: s_nxt.rdata = SCHEME_OUT_IN;
					OFS_VIEW: s_nxt.rdata[15:0] = {s_r.lamp, probe};
					default: s_nxt.rresp = RESP_SLVERR;
				endcase
			end
		end
		s_nxt.arready = !s_nxt.rvalid;

		// ***************************************************
		// Outputs
		// ***************************************************
		base = blocked ? {NRELAY{1'b0}} : SCHEME_OUT_IN;
		s_nxt.relay = s_r.contact_act ? (base | s_r.pattern) : base;
		s_nxt.lamp = lamp_act ? {NLAMP{1'b1}} : LAMP_IN;
		s_nxt.oos = in_test;
		s_nxt.alarm = in_test;
		s_nxt.freeze = in_test;
		s_nxt.cause = in_test && PROTO103_IN;
		s_nxt.ar_trip[0] = (s_r.ar_cmd == AR_3P);
		s_nxt.ar_trip[1] = (s_r.ar_cmd == AR_PA) && SP_AR_IN;
		s_nxt.ar_trip[2] = (s_r.ar_cmd == AR_PB) && SP_AR_IN;
		s_nxt.ar_trip[3] = (s_r.ar_cmd == AR_PC) && SP_AR_IN;
		s_nxt.paddr_out = (s_r.loop != LB_OFF) ? 16'h0000 : s_r.paddr;
		// The channel never stops for test modes; far ends stay live.
		s_nxt.tx_line = CHAN_TX_IN;
		s_nxt.rx_out = (s_r.loop == LB_INT) ? CHAN_TX_IN : CHAN_RX_LINE_IN;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			s_r <= '0;
			s_r.sel <= PROBE_SEL_RST;
			s_r.pattern <= PATTERN_RST;
			s_r.paddr <= PADDR_RST;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign AXI_AWREADY_OUT = s_r.awready;
	assign AXI_WREADY_OUT = s_r.wready;
	assign AXI_BVALID_OUT = s_r.bvalid;
	assign AXI_BRESP_OUT = s_r.bresp;
	assign AXI_ARREADY_OUT = s_r.arready;
	assign AXI_RVALID_OUT = s_r.rvalid;
	assign AXI_RDATA_OUT = s_r.rdata;
	assign AXI_RRESP_OUT = s_r.rresp;
	assign PROBE_OUT = probe;
	assign RELAY_OUT = s_r.relay;
	assign LAMP_OUT = s_r.lamp;
	assign OOS_OUT = s_r.oos;
	assign ALARM_OUT = s_r.alarm;
	assign FREEZE_OUT = s_r.freeze;
	assign CAUSE_TEST_OUT = s_r.cause;
	assign AR_TRIP_OUT = s_r.ar_trip;
	assign PROT_ADDR_OUT = s_r.paddr_out;
	assign CHAN_TX_LINE_OUT = s_r.tx_line;
	assign CHAN_RX_OUT = s_r.rx_out;

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	sequence s_lamp_on;
		(LAMP_OUT == 8'hFF) [*8];
	endsequence
	sequence s_contact_done;
		s_r.ccmd == CC_NOP && s_r.contact_act;
	endsequence

	property p_block;
		s_r.mode == TM_BLOCK && !s_r.contact_act |=> RELAY_OUT == 32'h0;
	endproperty
	a_block: assert property (p_block)
		else $error("Blocked test state still drives a relay.");

	property p_relay_view;
		AXI_ARVALID_IN && s_r.arready && AXI_ARADDR_IN == OFS_RELAY
			|=> AXI_RVALID_OUT && AXI_RDATA_OUT == $past(SCHEME_OUT_IN);
	endproperty
	a_relay_view: assert property (p_relay_view)
		else $error("Relay view does not show scheme commands.");

	property p_oos;
		s_r.mode != TM_OFF |=> OOS_OUT && ALARM_OUT && FREEZE_OUT;
	endproperty
	a_oos: assert property (p_oos)
		else $error("Test state did not take the relay out of service.");

	property p_opto_test;
		TEST_OPTO_IN |=> OOS_OUT;
	endproperty
	a_opto_test: assert property (p_opto_test)
		else $error("Test opto input did not enter the test state.");

	property p_loop_addr;
		s_r.loop != LB_OFF |=> PROT_ADDR_OUT == 16'h0000;
	endproperty
	a_loop_addr: assert property (p_loop_addr)
		else $error("Loopback did not force the address to zero.");

	property p_int_loop;
		s_r.loop == LB_INT |=> CHAN_RX_OUT == $past(CHAN_TX_IN);
	endproperty
	a_int_loop: assert property (p_int_loop)
		else $error("Internal loopback does not route tx to rx.");

	property p_chan_live;
		s_r.mode == TM_BLOCK |=> CHAN_TX_LINE_OUT == $past(CHAN_TX_IN);
	endproperty
	a_chan_live: assert property (p_chan_live)
		else $error("Channel stopped while outputs are blocked.");

	property p_lamp;
		s_r.lamp_go |=> ##1 s_lamp_on;
	endproperty
	a_lamp: assert property (p_lamp)
		else $error("Lamp test did not light all lamps.");

	property p_contact;
		s_r.ccmd == CC_APPLY |=> s_contact_done;
	endproperty
	a_contact: assert property (p_contact)
		else $error("Contact apply did not latch or revert.");

	property p_ar_clear;
		s_r.ar_cmd != AR_NOP && SCHEME_OUT_IN[AR_RELAY]
			&& !(s_r.aw_held && s_r.w_held) |=> s_r.ar_cmd == AR_NOP;
	endproperty
	a_ar_clear: assert property (p_ar_clear)
		else $error("Reclose test command did not revert at trip.");
endmodule

// >>> tb/cmt_scheme_model.sv
// Stand-in for the scheme logic that feeds the relay command bus.
// Assumes trip test requests are levels on the block's own clock.
`timescale 1ns/10ps
module cmt_scheme_model
	import cmt_pkg::*;
#(
	parameter int DELAY = 10
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] ar_trip_in,
	input wire logic [NRELAY-1:0] base_in,
	output logic [NRELAY-1:0] scheme_out
);
	int cnt;
	logic trip_r;
	// The trip test signal stays on output relay 3, bit 2 of the bus.
	always_comb begin
		scheme_out = base_in;
		scheme_out[AR_RELAY] = trip_r;
	end
	// A slow answer keeps the pending command visible for a while.
	always_ff @(posedge clk_in) begin
		if (!rstn_in || ar_trip_in == 4'h0) begin
			cnt <= 0;
			trip_r <= 1'b0;
		end else if (cnt == DELAY) begin
			trip_r <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> tb/tb_commissioning_test_control.sv
// Self-checking bench of the commissioning test control block.
// Assumes the package constants and a short lamp interval of 20 cycles.
`timescale 1ns/10ps
module tb_commissioning_test_control
	import cmt_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'hF;
	logic [BUS_W-1:0] ibus = '0;
	logic [31:0] opto = 32'h0, base = 32'h0, relay, scheme, rd;
	logic [7:0] lamp = 8'h00, lamp_o, probe;
	logic topto = 1'b0, spar = 1'b0, p103 = 1'b0, ctx = 1'b0, crx = 1'b0;
	logic awr, wr, bv, arr, rv, oos, alarm, frz, cause, ctxl, crxo;
	logic [1:0] br, rr;
	logic [3:0] art;
	logic [15:0] paddr;
	int fails = 0, checks_done = 0, cyc = 0;

	always #25 ref_clk = ~ref_clk;

	cmt_top #(.LAMP_TICKS(20)) dut (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn),
		.AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
		.AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_WVALID_IN(wv),
		.AXI_WREADY_OUT(wr), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv),
		.AXI_BREADY_IN(bre), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
		.AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rd), .AXI_RRESP_OUT(rr),
		.AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre), .INT_BUS_IN(ibus),
		.OPTO_IN(opto), .SCHEME_OUT_IN(scheme), .LAMP_IN(lamp),
		.TEST_OPTO_IN(topto), .SP_AR_IN(spar), .PROTO103_IN(p103),
		.CHAN_TX_IN(ctx), .CHAN_RX_LINE_IN(crx), .PROBE_OUT(probe),
		.RELAY_OUT(relay), .LAMP_OUT(lamp_o), .OOS_OUT(oos),
		.ALARM_OUT(alarm), .FREEZE_OUT(frz), .CAUSE_TEST_OUT(cause),
		.AR_TRIP_OUT(art), .PROT_ADDR_OUT(paddr), .CHAN_TX_LINE_OUT(ctxl),
		.CHAN_RX_OUT(crxo));

	cmt_scheme_model partner (.clk_in(ref_clk), .rstn_in(rstn),
		.ar_trip_in(art), .base_in(base), .scheme_out(scheme));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake would stall the run, so a cycle ceiling cuts it.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		r = br;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		d = rd;
		r = rr;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr_reg(a, d, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask

	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd_reg(a, d, r);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
		chk(n, e, d);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rchk("sel0", OFS_PROBE0, 32'h40);
		rchk("sel7", 8'h1C, 32'h47);
		rchk("pattern", OFS_PATTERN, 32'h0);
		rchk("mode", OFS_MODE, 32'h0);
		wr_reg(8'h80, 32'hFFFF_FFFF, r);
		chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
		rd_reg(8'h80, d, r);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped rdata", 32'h0, d);
		$display("reset test done");
	endtask

	task automatic t_views();
		ibus[511] <= 1'b1;
		ibus[65] <= 1'b1;
		lamp <= 8'hA5;
		opto <= 32'h8000_0001;
		base <= 32'h0000_0011;
		w(OFS_PROBE0, 32'h1FF);
		tick(3);
		chk("probe pins", 32'h03, 32'(probe));
		rchk("view", OFS_VIEW, 32'h0000_A503);
		chk("lamps", 32'hA5, 32'(lamp_o));
		rchk("opto", OFS_OPTO, 32'h8000_0001);
		rchk("relay view", OFS_RELAY, 32'h11);
		chk("relay pins", 32'h11, relay);
		$display("view test done");
	endtask

	task automatic t_mode();
		p103 <= 1'b1;
		w(OFS_MODE, 32'(TM_TEST));
		tick(3);
		chk("oos", 32'h1, 32'(oos));
		chk("alarm", 32'h1, 32'(alarm));
		chk("freeze", 32'h1, 32'(frz));
		chk("cause", 32'h1, 32'(cause));
		chk("relay in test", 32'h11, relay);
		w(OFS_MODE, 32'(TM_BLOCK));
		ctx <= 1'b1;
		tick(3);
		chk("relay blocked", 32'h0, relay);
		rchk("relay view", OFS_RELAY, 32'h11);
		rchk("status", OFS_STATUS, 32'h3);
		chk("chan line", 32'h1, 32'(ctxl));
		w(OFS_MODE, 32'(TM_OFF));
		tick(3);
		chk("oos off", 32'h0, 32'(oos));
		chk("relay back", 32'h11, relay);
		topto <= 1'b1;
		p103 <= 1'b0;
		tick(3);
		chk("oos opto", 32'h1, 32'(oos));
		chk("cause off", 32'h0, 32'(cause));
		topto <= 1'b0;
		tick(3);
		$display("mode test done");
	endtask

	task automatic t_tests();
		w(OFS_PATTERN, 32'hC000_0100);
		w(OFS_CMD, 32'(CC_APPLY));
		tick(3);
		chk("contacts on", 32'hC000_0111, relay);
		rchk("cmd", OFS_CMD, 32'h0);
		w(OFS_CMD, 32'(CC_REMOVE));
		tick(3);
		chk("contacts off", 32'h11, relay);
		w(OFS_CMD, 32'h4);
		tick(3);
		chk("lamps lit", 32'hFF, 32'(lamp_o));
		rchk("lamp cmd", OFS_CMD, 32'h4);
		tick(30);
		chk("lamps back", 32'hA5, 32'(lamp_o));
		rchk("lamp cmd off", OFS_CMD, 32'h0);
		w(OFS_CMD, 32'(AR_PA) << 4);
		tick(3);
		chk("ar single off", 32'h0, 32'(art));
		rchk("ar dropped", OFS_CMD, 32'h0);
		spar <= 1'b1;
		for (int k = 1; k <= 4; k++) begin
			w(OFS_CMD, 32'(k) << 4);
			rchk("ar pending", OFS_CMD, 32'(k) << 4);
			chk("ar trip", 32'h1 << (k - 1), 32'(art));
			tick(20);
			chk("ar trip off", 32'h0, 32'(art));
			rchk("ar cmd", OFS_CMD, 32'h0);
		end
		$display("contact lamp reclose test done");
	endtask

	task automatic t_loop();
		w(OFS_PADDR, 32'h1234);
		tick(3);
		chk("addr", 32'h1234, 32'(paddr));
		w(OFS_LOOP, 32'(LB_EXT));
		tick(3);
		chk("addr ext", 32'h0, 32'(paddr));
		w(OFS_LOOP, 32'(LB_INT));
		ctx <= 1'b0;
		crx <= 1'b1;
		tick(3);
		chk("addr int", 32'h0, 32'(paddr));
		chk("rx low", 32'h0, 32'(crxo));
		ctx <= 1'b1;
		crx <= 1'b0;
		tick(3);
		chk("rx high", 32'h1, 32'(crxo));
		$display("loopback test done");
	endtask

	initial begin
		tick(6);
		rstn <= 1'b1;
		tick(1);
		t_reset();
		t_views();
		t_mode();
		t_tests();
		t_loop();
		give_verdict();
	end
endmodule
